// ---- hw/bsd_status_display.sv ----
// top of the burner status display: indicators and seven-segment view
`timescale 1ns/10ps

// Notes on behaviour
// [RL1] power indicator lit while supply present
// [RL2] event indicator lit while event active
// [RL3] shutter indicator lit while shutter closed
// [RL4] flame indicator on only with flame
// [RL5] flame colour from voltage thresholds
// [RL6] alarm indicator lit while alarm present
// [RL7] start indicator follows contact, off on alarm
// [RL8] ignition indicator follows ignition output
// [RL9] pilot indicator follows pilot valve output
// [RL10] main indicator follows main valve output
// [RL11] normal view shows stage code P1..PL
// [RL12] standby shown as distinct dashes
// [RL13] lockout forces alternating alarm view
// [RL14] codes EO, E1, E2 for causes
// [RL15] E3 for flame with shutter off
// [RL16] E4 for ignition failure
// [RL17] E5 for flame loss later
// [RL18] EE for unknown cause
// [RL19] button toggles voltage and alarm view
// [RL20] pre-lockout view restored after reset; an event view returns as the normal view
// [RL21] voltage shown as two digits, one decimal
// [RL22] press shows event code, never in lockout
// [RL23] two second hold clears events
// [RL24] alternation about one second per item
// [RL25] button debounced, one press one change
module bsd_status_display (
  input  wire logic                        ref_clk,
  input  wire logic                        rstn,
  input  wire logic                        power_good,
  input  wire logic [7:0]                  event_active,
  input  wire logic                        shutter_closed,
  input  wire logic                        flame_detected,
  input  wire logic [bsd_pkg::VOLT_W-1:0]  flame_volt,
  input  wire logic [bsd_pkg::VOLT_W-1:0]  green_min,
  input  wire logic [bsd_pkg::VOLT_W-1:0]  red_max,
  input  wire logic                        alarm_present,
  input  wire logic                        start_contact,
  input  wire logic                        ignition_out,
  input  wire logic                        pilot_valve_out,
  input  wire logic                        main_valve_out,
  input  wire bsd_pkg::bsd_stage_t         stage,
  input  wire bsd_pkg::bsd_alarm_t         alarm_cause,
  input  wire logic                        display_push_button,
  output logic                             power_indicator,
  output logic                             event_indicator,
  output logic                             shutter_indicator,
  output logic                             flame_green,
  output logic                             flame_orange,
  output logic                             flame_red,
  output logic                             alarm_indicator,
  output logic                             start_indicator,
  output logic                             ignition_indicator,
  output logic                             pilot_valve_indicator,
  output logic                             main_valve_indicator,
  output logic [6:0]                       seg_hi,
  output logic [6:0]                       seg_lo,
  output logic                             seg_point,
  output logic                             events_clear
);

  logic [1:0]                rst_pipe;
  logic                      rst_sync_n;
  logic [1:0]                btn_meta;
  logic                      btn_sync;
  logic                      press;
  logic                      hold;
  logic                      locked;
  logic                      locked_q;
  bsd_pkg::bsd_view_t        view;
  bsd_pkg::bsd_view_t        saved_view;
  logic [bsd_pkg::CNT_W-1:0] alt_cnt;
  logic                      alt_phase;
  logic [2:0]                ev_idx;
  logic [1:0]                colour;
  logic [3:0]                v_int;
  logic [3:0]                v_frac;
  bsd_dig_if                 dig ();

  // reset release through two flops; assertion stays asynchronous
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rst_pipe <= 2'h0;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end
  assign rst_sync_n = rst_pipe[1];

  // panel button arrives from a pin, two flops before use
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      btn_meta <= 2'h0;
    end else begin
      btn_meta <= {btn_meta[0], display_push_button};
    end
  end
  assign btn_sync = btn_meta[1];

  // [RL25] debounce the button
  bsd_button u_button (
    .ref_clk    (ref_clk),
    .rst_sync_n (rst_sync_n),
    .btn_sync   (btn_sync),
    .press      (press),
    .hold       (hold)
  );

  assign locked = (stage == bsd_pkg::BSD_LOCK);

  // [RL23] hold clears events
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      events_clear <= 1'b0;
    end else begin
      events_clear <= hold;
    end
  end

  // colour thresholds; orange is the band between them
  always_comb begin
    // [RL5] colour by voltage
    if (flame_volt >= green_min) begin
      colour = bsd_pkg::COL_GREEN;
    end else if (flame_volt <= red_max) begin
      colour = bsd_pkg::COL_RED;
    end else begin
      colour = bsd_pkg::COL_ORANGE;
    end
  end

  // indicator lamps, registered to keep them steady on pins
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      power_indicator       <= 1'b0;
      event_indicator       <= 1'b0;
      shutter_indicator     <= 1'b0;
      flame_green           <= 1'b0;
      flame_orange          <= 1'b0;
      flame_red             <= 1'b0;
      alarm_indicator       <= 1'b0;
      start_indicator       <= 1'b0;
      ignition_indicator    <= 1'b0;
      pilot_valve_indicator <= 1'b0;
      main_valve_indicator  <= 1'b0;
    end else begin
      // [RL1] power lamp
      power_indicator       <= power_good;
      // [RL2] event lamp
      event_indicator       <= |event_active;
      // [RL3] shutter lamp
      shutter_indicator     <= shutter_closed;
      // [RL4] flame lamp gated
      flame_green  <= flame_detected && colour == bsd_pkg::COL_GREEN;
      flame_orange <= flame_detected && colour == bsd_pkg::COL_ORANGE;
      flame_red    <= flame_detected && colour == bsd_pkg::COL_RED;
      // [RL6] alarm lamp
      alarm_indicator       <= alarm_present;
      // [RL7] start lamp, alarm wins
      start_indicator       <= start_contact && !alarm_present;
      // [RL8] ignition lamp
      ignition_indicator    <= ignition_out;
      // [RL9] pilot lamp
      pilot_valve_indicator <= pilot_valve_out;
      // [RL10] main lamp
      main_valve_indicator  <= main_valve_out;
    end
  end

  // lockout edge tracking
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      locked_q <= 1'b0;
    end else begin
      locked_q <= locked;
    end
  end

  // view selection: lockout takes over, button steps views
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      view       <= bsd_pkg::BSD_V_SEQ;
      saved_view <= bsd_pkg::BSD_V_SEQ;
    end else if (locked && !locked_q) begin
      // [RL13] auto alarm view
      view <= bsd_pkg::BSD_V_ALARM;
      // [RL20] remember prior view, an event view as the normal view
      saved_view <= (view == bsd_pkg::BSD_V_EVENT) ? bsd_pkg::BSD_V_SEQ
                                                   : view;
    end else if (!locked && locked_q) begin
      // [RL20] restore after reset
      view <= saved_view;
    end else if (press) begin
      unique case (view)
        // [RL19] alarm to voltage
        bsd_pkg::BSD_V_ALARM: view <= bsd_pkg::BSD_V_VOLT;
        bsd_pkg::BSD_V_VOLT:
          view <= locked ? bsd_pkg::BSD_V_ALARM : bsd_pkg::BSD_V_SEQ;
        // [RL22] event view only unlocked
        bsd_pkg::BSD_V_SEQ:
          view <= (|event_active && !locked) ? bsd_pkg::BSD_V_EVENT
                                             : bsd_pkg::BSD_V_VOLT;
        bsd_pkg::BSD_V_EVENT: view <= bsd_pkg::BSD_V_VOLT;
      endcase
    end else if (view == bsd_pkg::BSD_V_EVENT &&
                 (!(|event_active) || locked)) begin
      // leave event view when nothing is left to show
      view <= bsd_pkg::BSD_V_SEQ;
    end
  end

  // [RL24] one second alternation
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      alt_cnt   <= '0;
      alt_phase <= 1'b0;
    end else if (view != bsd_pkg::BSD_V_ALARM) begin
      alt_cnt   <= '0;
      alt_phase <= 1'b0;
    end else if (alt_cnt == bsd_pkg::CNT_W'(bsd_pkg::ALT_CYC - 1)) begin
      alt_cnt   <= '0;
      alt_phase <= ~alt_phase;
    end else begin
      alt_cnt <= alt_cnt + 1'b1;
    end
  end

  // lowest active event number for the event view
  always_comb begin
    ev_idx = 3'h0;
    for (int i = 7; i >= 0; i--) begin
      if (event_active[i]) begin
        ev_idx = 3'(i);
      end
    end
  end

  // [RL21] volts and tenths
  always_comb begin
    logic [6:0] v;
    v      = (flame_volt > bsd_pkg::VOLT_MAX) ? bsd_pkg::VOLT_MAX
                                              : flame_volt;
    v_int  = 4'(v / 7'h0A);
    v_frac = 4'(v % 7'h0A);
  end

  // character choice per view
  always_comb begin
    dig.char_hi = bsd_pkg::CH_BLANK;
    dig.char_lo = bsd_pkg::CH_BLANK;
    dig.point   = 1'b0;
    unique case (view)
      bsd_pkg::BSD_V_VOLT: begin
        dig.char_hi = {1'b0, v_int};
        dig.char_lo = {1'b0, v_frac};
        dig.point   = 1'b1;
      end
      bsd_pkg::BSD_V_EVENT: begin
        dig.char_hi = bsd_pkg::CH_A;
        dig.char_lo = {1'b0, 4'(ev_idx) + 4'h1};
      end
      bsd_pkg::BSD_V_ALARM: begin
        if (!alt_phase) begin
          dig.char_hi = bsd_pkg::CH_P;
          dig.char_lo = bsd_pkg::CH_L;
        end else begin
          dig.char_hi = bsd_pkg::CH_E;
          unique case (alarm_cause)
            // [RL14] start, interlock, false flame
            bsd_pkg::BSD_AL_START:  dig.char_lo = bsd_pkg::CH_O;
            bsd_pkg::BSD_AL_ILOCK:  dig.char_lo = 5'h01;
            bsd_pkg::BSD_AL_FALSE:  dig.char_lo = 5'h02;
            // [RL15] uv alarm code
            bsd_pkg::BSD_AL_UV:     dig.char_lo = 5'h03;
            // [RL16] ignition failure code
            bsd_pkg::BSD_AL_IGNF:   dig.char_lo = 5'h04;
            // [RL17] flame failure code
            bsd_pkg::BSD_AL_FLAMEF: dig.char_lo = 5'h05;
            // [RL18] unknown cause, also illegal codes
            default:                dig.char_lo = bsd_pkg::CH_E;
          endcase
        end
      end
      bsd_pkg::BSD_V_SEQ: begin
        if (stage == bsd_pkg::BSD_STANDBY) begin
          // [RL12] standby dashes
          dig.char_hi = bsd_pkg::CH_DASH;
          dig.char_lo = bsd_pkg::CH_DASH;
        end else begin
          // [RL11] stage code
          dig.char_hi = bsd_pkg::CH_P;
          dig.char_lo = locked ? bsd_pkg::CH_L : {2'h0, stage};
        end
      end
    endcase
  end

  // segment decode and output register
  bsd_seg_drive u_seg (
    .ref_clk    (ref_clk),
    .rst_sync_n (rst_sync_n),
    .dig        (dig.dst),
    .seg_hi     (seg_hi),
    .seg_lo     (seg_lo),
    .seg_point  (seg_point)
  );
endmodule // bsd_status_display

// ---- hw/bsd_pkg.sv ----
// package of constants and types for the burner status display
package bsd_pkg;

  localparam int unsigned CLK_HZ = 50_000_000;
  // alternation period per item, ms
  localparam int unsigned ALT_MS = 1000;
  localparam int unsigned ALT_CYC = CLK_HZ / 1000 * ALT_MS;
  // button debounce settle time, ms
  localparam int unsigned DEB_MS = 20;
  localparam int unsigned DEB_CYC = CLK_HZ / 1000 * DEB_MS;
  // long hold for clearing events, ms
  localparam int unsigned HOLD_MS = 2000;
  localparam int unsigned HOLD_CYC = CLK_HZ / 1000 * HOLD_MS;
  localparam int CNT_W = 27;

  // flame voltage in tenths of a volt
  localparam int VOLT_W = 7;
  localparam logic [6:0] GREEN_MIN_DEF = 7'h19;  // 2.5 V
  localparam logic [6:0] RED_MAX_DEF = 7'h0F;  // 1.5 V
  localparam logic [6:0] VOLT_MAX = 7'h63;  // 9.9 V

  // sequence stages
  typedef enum logic [2:0] {
    BSD_STANDBY = 3'h0,
    BSD_START   = 3'h1,
    BSD_IGN     = 3'h2,
    BSD_PILOT   = 3'h3,
    BSD_MAIN    = 3'h4,
    BSD_RUN     = 3'h5,
    BSD_LOCK    = 3'h6
  } bsd_stage_t;

  // lockout alarm causes
  typedef enum logic [2:0] {
    BSD_AL_START  = 3'h0,
    BSD_AL_ILOCK  = 3'h1,
    BSD_AL_FALSE  = 3'h2,
    BSD_AL_UV     = 3'h3,
    BSD_AL_IGNF   = 3'h4,
    BSD_AL_FLAMEF = 3'h5,
    BSD_AL_OTHER  = 3'h6
  } bsd_alarm_t;

  // views of the display
  typedef enum logic [1:0] {
    BSD_V_SEQ   = 2'h0,
    BSD_V_VOLT  = 2'h1,
    BSD_V_EVENT = 2'h2,
    BSD_V_ALARM = 2'h3
  } bsd_view_t;

  // flame colour
  localparam logic [1:0] COL_GREEN = 2'h0;
  localparam logic [1:0] COL_ORANGE = 2'h1;
  localparam logic [1:0] COL_RED = 2'h2;

  // character codes for the digit decoder
  localparam logic [4:0] CH_BLANK = 5'h10;
  localparam logic [4:0] CH_P = 5'h11;
  localparam logic [4:0] CH_L = 5'h12;
  localparam logic [4:0] CH_E = 5'h13;
  localparam logic [4:0] CH_A = 5'h14;
  localparam logic [4:0] CH_DASH = 5'h15;
  localparam logic [4:0] CH_O = 5'h16;

  // segments gfedcba, active high
  function automatic logic [6:0] seg_of(input logic [4:0] ch);
    unique case (ch)
      5'h00: seg_of = 7'h3F;
      5'h01: seg_of = 7'h06;
      5'h02: seg_of = 7'h5B;
      5'h03: seg_of = 7'h4F;
      5'h04: seg_of = 7'h66;
      5'h05: seg_of = 7'h6D;
      5'h06: seg_of = 7'h7D;
      5'h07: seg_of = 7'h07;
      5'h08: seg_of = 7'h7F;
      5'h09: seg_of = 7'h6F;
      CH_P:  seg_of = 7'h73;
      CH_L:  seg_of = 7'h38;
      CH_E:  seg_of = 7'h79;
      CH_A:  seg_of = 7'h77;
      CH_DASH: seg_of = 7'h40;
      CH_O:  seg_of = 7'h3F;
      default: seg_of = 7'h00;
    endcase
  endfunction

endpackage

// ---- hw/bsd_display_push_button_if.sv ----
// interface carrying the two display characters to the segment driver
`timescale 1ns/10ps
interface bsd_dig_if;
  logic [4:0] char_hi;
  logic [4:0] char_lo;
  logic       point;
  modport src (output char_hi, output char_lo, output point);
  modport dst (input char_hi, input char_lo, input point);
endinterface // bsd_dig_if

// ---- hw/bsd_button.sv ----
// debouncer for the display push button with press and hold outputs
`timescale 1ns/10ps
module bsd_button (
  input  wire logic ref_clk,
  input  wire logic rst_sync_n,
  input  wire logic btn_sync,
  output logic      press,
  output logic      hold
);
  logic [bsd_pkg::CNT_W-1:0] deb_cnt;
  logic [bsd_pkg::CNT_W-1:0] hold_cnt;
  logic                      level;
  logic                      held_done;

  // settle counter: level follows input only after it stays put
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      deb_cnt <= '0;
      level   <= 1'b0;
    end else if (btn_sync == level) begin
      deb_cnt <= '0;
    end else if (deb_cnt == bsd_pkg::CNT_W'(bsd_pkg::DEB_CYC - 1)) begin
      deb_cnt <= '0;
      level   <= btn_sync;
    end else begin
      deb_cnt <= deb_cnt + 1'b1;
    end
  end

  // press pulse on the debounced rising edge only
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      press <= 1'b0;
    end else begin
      press <= (deb_cnt == bsd_pkg::CNT_W'(bsd_pkg::DEB_CYC - 1)) &&
               btn_sync && !level;
    end
  end

  // hold pulse fires once per press after the long hold
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      hold_cnt  <= '0;
      held_done <= 1'b0;
      hold      <= 1'b0;
    end else begin
      hold <= 1'b0;
      if (!level) begin
        hold_cnt  <= '0;
        held_done <= 1'b0;
      end else if (!held_done) begin
        if (hold_cnt == bsd_pkg::CNT_W'(bsd_pkg::HOLD_CYC - 1)) begin
          hold      <= 1'b1;
          held_done <= 1'b1;
        end else begin
          hold_cnt <= hold_cnt + 1'b1;
        end
      end
    end
  end
endmodule // bsd_button

// ---- hw/bsd_seg_drive.sv ----
// seven-segment decoder for the two display digits
`timescale 1ns/10ps
module bsd_seg_drive (
  input  wire logic       ref_clk,
  input  wire logic       rst_sync_n,
  bsd_dig_if.dst          dig,
  output logic      [6:0] seg_hi,
  output logic      [6:0] seg_lo,
  output logic            seg_point
);
  // registered so the segment pins never glitch between views
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      seg_hi    <= 7'h00;
      seg_lo    <= 7'h00;
      seg_point <= 1'b0;
    end else begin
      seg_hi    <= bsd_pkg::seg_of(dig.char_hi);
      seg_lo    <= bsd_pkg::seg_of(dig.char_lo);
      seg_point <= dig.point;
    end
  end
endmodule // bsd_seg_drive

// ---- dv/bsd_status_display_properties.sv ----
// port-level checks of the burner status display
`timescale 1ns/10ps
module bsd_status_display_properties (
  input wire logic                flame_red,
  input wire logic                ref_clk,
  input wire logic                rstn,
  input wire logic                power_good,
  input wire logic [7:0]          event_active,
  input wire logic                shutter_closed,
  input wire logic                flame_detected,
  input wire logic [6:0]          flame_volt,
  input wire logic [6:0]          green_min,
  input wire logic [6:0]          red_max,
  input wire logic                alarm_present,
  input wire logic                start_contact,
  input wire logic                ignition_out,
  input wire logic                pilot_valve_out,
  input wire logic                main_valve_out,
  input wire bsd_pkg::bsd_stage_t stage,
  input wire logic                power_indicator,
  input wire logic                event_indicator,
  input wire logic                shutter_indicator,
  input wire logic                flame_green,
  input wire logic                flame_orange,
  input wire logic                alarm_indicator,
  input wire logic                start_indicator,
  input wire logic                ignition_indicator,
  input wire logic                pilot_valve_indicator,
  input wire logic                main_valve_indicator,
  input wire logic [6:0]          seg_hi,
  input wire logic [6:0]          seg_lo,
  input wire logic                events_clear
);
  logic [2:0] up;
  logic       rdy;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  // wait out the two-flop reset release before judging lamps
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) up <= 3'h0;
    else if (up != 3'h7) up <= up + 3'h1;
  end
  assign rdy = (up == 3'h7);

  chk_power_lamp: assert property (rdy |->
    power_indicator == $past(power_good)) else $error("power lamp");
  chk_event_lamp: assert property (rdy |->
    event_indicator == ($past(event_active) != 8'h00)) else $error("event");
  chk_shutter_lamp: assert property (rdy |->
    shutter_indicator == $past(shutter_closed)) else $error("shutter");
  chk_flame_dark: assert property (rdy && !$past(flame_detected) |->
    !(flame_green || flame_orange || flame_red)) else $error("flame lit");
  chk_flame_colour: assert property (rdy && $past(flame_detected) |->
    $onehot({flame_green, flame_orange, flame_red})
    && flame_green == ($past(flame_volt) >= $past(green_min))
    && flame_red == ($past(flame_volt) <= $past(red_max)))
    else $error("flame colour");
  chk_alarm_lamp: assert property (rdy |->
    alarm_indicator == $past(alarm_present)) else $error("alarm lamp");
  chk_start_lamp: assert property (rdy |->
    start_indicator == ($past(start_contact) && !$past(alarm_present)))
    else $error("start lamp");
  chk_load_lamps: assert property (rdy |->
    ignition_indicator == $past(ignition_out)
    && pilot_valve_indicator == $past(pilot_valve_out)
    && main_valve_indicator == $past(main_valve_out)) else $error("loads");
  chk_lock_code: assert property (rdy && stage == bsd_pkg::BSD_LOCK
    && $past(stage) != bsd_pkg::BSD_LOCK |-> ##[1:4]
    (seg_hi == 7'h73 && seg_lo == 7'h38)) else $error("lockout code");
  chk_clear_pulse: assert property (events_clear |=> !events_clear)
    else $error("clear pulse too long");

  cover property (rdy && stage == bsd_pkg::BSD_LOCK);
  cover property (rdy && flame_orange);
  cover property (rdy && start_indicator && main_valve_indicator);
endmodule // bsd_status_display_properties

bind bsd_status_display bsd_status_display_properties u_chk (.*);

// ---- dv/bsd_burner_model.sv ----
// sequencer model: stage and load outputs as the far side drives them
`timescale 1ns/10ps
module bsd_burner_model (
  input  wire logic                ref_clk,
  input  wire bsd_pkg::bsd_stage_t stage_req,
  output bsd_pkg::bsd_stage_t      stage,
  output logic                     ignition_out,
  output logic                     pilot_valve_out,
  output logic                     main_valve_out,
  output logic                     start_contact
);
  initial stage = bsd_pkg::BSD_STANDBY;
  // stage moves one edge after the request, like a real sequencer step
  always @(posedge ref_clk) stage <= stage_req;
  // loads follow the stage; interrupted pilot drops once running
  assign ignition_out    = (stage == bsd_pkg::BSD_IGN);
  assign pilot_valve_out = (stage >= bsd_pkg::BSD_IGN)
                           && (stage <= bsd_pkg::BSD_MAIN);
  assign main_valve_out  = (stage == bsd_pkg::BSD_MAIN)
                           || (stage == bsd_pkg::BSD_RUN);
  assign start_contact   = (stage != bsd_pkg::BSD_STANDBY);
endmodule // bsd_burner_model

// ---- dv/bsd_status_display_tb.sv ----
// self-checking bench of the burner status display
`timescale 1ns/10ps
module bsd_status_display_tb;
  logic                ref_clk, rstn, power_good, shutter_closed;
  logic                flame_detected, alarm_present, display_push_button;
  logic [7:0]          event_active;
  logic [6:0]          flame_volt, green_min, red_max, seg_hi, seg_lo;
  logic                power_indicator, event_indicator, shutter_indicator;
  logic                flame_green, flame_orange, flame_red, seg_point;
  logic                alarm_indicator, start_indicator, ignition_indicator;
  logic                pilot_valve_indicator, main_valve_indicator;
  logic                ignition_out, pilot_valve_out, main_valve_out;
  logic                start_contact, events_clear, clr_seen;
  bsd_pkg::bsd_stage_t stage_req, stage;
  bsd_pkg::bsd_alarm_t alarm_cause;
  int                  mismatches, checks, cyc;
  logic [6:0]          cv [0:4] = '{7'h0F, 7'h10, 7'h18, 7'h19, 7'h63};

  bsd_burner_model u_burner (.ref_clk(ref_clk), .stage_req(stage_req),
    .stage(stage), .ignition_out(ignition_out), .start_contact(start_contact),
    .pilot_valve_out(pilot_valve_out), .main_valve_out(main_valve_out));

  bsd_status_display u_dut (.ref_clk(ref_clk), .rstn(rstn),
    .power_good(power_good), .event_active(event_active),
    .shutter_closed(shutter_closed), .flame_detected(flame_detected),
    .flame_volt(flame_volt), .green_min(green_min), .red_max(red_max),
    .alarm_present(alarm_present), .start_contact(start_contact),
    .ignition_out(ignition_out), .pilot_valve_out(pilot_valve_out),
    .main_valve_out(main_valve_out), .stage(stage),
    .alarm_cause(alarm_cause), .display_push_button(display_push_button),
    .power_indicator(power_indicator), .event_indicator(event_indicator),
    .shutter_indicator(shutter_indicator), .flame_green(flame_green),
    .flame_orange(flame_orange), .flame_red(flame_red),
    .alarm_indicator(alarm_indicator), .start_indicator(start_indicator),
    .ignition_indicator(ignition_indicator), .seg_hi(seg_hi),
    .pilot_valve_indicator(pilot_valve_indicator), .seg_lo(seg_lo),
    .main_valve_indicator(main_valve_indicator), .seg_point(seg_point),
    .events_clear(events_clear));

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  // hang guard, well above the few thousand cycles the run needs
  always @(posedge ref_clk) begin
    cyc++;
    if (events_clear === 1'b1) clr_seen = 1'b1;
    if (cyc == 20000) begin
      mismatches++;
      test_done();
    end
  end

  task automatic cmp(input logic [13:0] seen, input logic [13:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic test_done;
    if (mismatches == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  // colour as {green, orange, red}
  function automatic logic [2:0] col(input logic f, input logic [6:0] v,
                                     input logic [6:0] g, input logic [6:0] r);
    if (!f) return 3'h0;
    if (v >= g) return 3'h4;
    if (v <= r) return 3'h1;
    return 3'h2;
  endfunction

  // stage code segments: dashes in standby, P then digit or L
  function automatic logic [13:0] code(input logic [2:0] s);
    logic [6:0] d [0:6];
    d = '{7'h40, 7'h06, 7'h5B, 7'h4F, 7'h66, 7'h6D, 7'h38};
    return {(s == 3'h0) ? 7'h40 : 7'h73, d[s]};
  endfunction

  function automatic logic [13:0] lamps_exp();
    return {6'h00, power_good, |event_active, shutter_closed, alarm_present,
            start_contact & ~alarm_present, ignition_out, pilot_valve_out,
            main_valve_out};
  endfunction

  function automatic logic [13:0] lamps();
    return {6'h00, power_indicator, event_indicator, shutter_indicator,
            alarm_indicator, start_indicator, ignition_indicator,
            pilot_valve_indicator, main_valve_indicator};
  endfunction

  initial begin
    {rstn, power_good, shutter_closed, flame_detected} = 4'h0;
    {alarm_present, display_push_button, clr_seen} = 3'h0;
    event_active = 8'h00;
    flame_volt = 7'h00;
    green_min = bsd_pkg::GREEN_MIN_DEF;
    red_max = bsd_pkg::RED_MAX_DEF;
    stage_req = bsd_pkg::BSD_STANDBY;
    alarm_cause = bsd_pkg::BSD_AL_START;
    void'($urandom(32'hE2A5));
    repeat (10) @(posedge ref_clk);
    rstn <= 1'b1;
    step(3);
    // random lamp inputs, stages and thresholds
    repeat (200) begin
      @(posedge ref_clk);
      power_good <= 1'($urandom);
      shutter_closed <= 1'($urandom);
      flame_detected <= 1'($urandom);
      alarm_present <= 1'($urandom);
      event_active <= ($urandom % 3 == 0) ? 8'($urandom) : 8'h00;
      flame_volt <= 7'($urandom % 100);
      green_min <= 7'(20 + $urandom % 11);
      red_max <= 7'(10 + $urandom % 10);
      stage_req <= bsd_pkg::bsd_stage_t'($urandom % 6);
      step(4);
      cmp(lamps(), lamps_exp());
      cmp(14'({flame_green, flame_orange, flame_red}),
          14'(col(flame_detected, flame_volt, green_min, red_max)));
      cmp({seg_hi, seg_lo}, code(stage));
    end
    // colour band edges at default thresholds
    foreach (cv[i]) begin
      @(posedge ref_clk);
      {flame_detected, flame_volt} <= {1'b1, cv[i]};
      green_min <= bsd_pkg::GREEN_MIN_DEF;
      red_max <= bsd_pkg::RED_MAX_DEF;
      step(3);
      cmp(14'({flame_green, flame_orange, flame_red}),
          14'(col(1'b1, cv[i], 7'h19, 7'h0F)));
    end
    // lockout for every cause, then back to start check
    for (int c = 0; c < 7; c++) begin
      @(posedge ref_clk);
      stage_req <= bsd_pkg::BSD_LOCK;
      alarm_cause <= bsd_pkg::bsd_alarm_t'(c);
      alarm_present <= 1'b1;
      step(8);
      cmp({seg_hi, seg_lo}, code(3'h6));
      cmp(14'(start_indicator), 14'h0000);
      @(posedge ref_clk);
      stage_req <= bsd_pkg::BSD_START;
      alarm_present <= 1'b0;
      step(8);
      cmp({seg_hi, seg_lo}, code(3'h1));
    end
    // bounces far shorter than the debounce must change nothing
    @(posedge ref_clk);
    stage_req <= bsd_pkg::BSD_PILOT;
    repeat (5) begin
      @(posedge ref_clk);
      display_push_button <= 1'b1;
      step(400);
      @(posedge ref_clk);
      display_push_button <= 1'b0;
      step(400);
    end
    cmp({seg_hi, seg_lo}, code(3'h3));
    cmp(14'(clr_seen), 14'h0000);
    // second reset in mid-run clears the lamps, release restores them
    @(posedge ref_clk);
    {rstn, power_good} <= 2'h1;
    step(3);
    cmp({power_indicator, seg_hi, seg_point, 5'h00}, 14'h0000);
    @(posedge ref_clk);
    rstn <= 1'b1;
    step(5);
    cmp(lamps(), lamps_exp());
    test_done();
  end
endmodule // bsd_status_display_tb
